// [rtl/pbs_binning.sv]
// pixel binning and same-colour sub-sampling stage
//
// Behaviour
// - Horizontal binning sums 2, 4 or 8 neighbouring line pixels, counting black level once.
// - Vertical binning adds 2, 4 or 8 vertical neighbours, cutting line count by that factor.
// - Full binning combines vertical neighbours first, then horizontal, giving 4, 16 or 64.
// - Factors 2, 4 and 8 work independently in each direction and combined.
// - Binning leaves the offset, brightness and black level settings untouched.
// - Only vertical binning speeds frames up; horizontal binning keeps line timing.
// - Binning exists only on monochrome parts; sub-sampling on colour and monochrome.
// - Sub-sampling drops same-colour neighbours instead of summing them.
// - Horizontal, vertical and both-way sub-sampling keep 2 of 4, 8 or 16 pixels.
// - By default mode 1 is 2x horizontal, mode 2 2x vertical, mode 3 2x full binning.
// - By default modes 4, 5, 6 are 2 of 4 sub-sampling horizontal, vertical and both.
// - A mode change that alters image size marks shading references as stale.
// - Binning and sub-sampling are never applied together.
// - Mode 0 stays full resolution; modes 1 to 7 carry up to 7 mapped modes.
`timescale 1ns/1ps
`default_nettype none

module pbs_binning
   import pbs_pkg::*;
#(
   parameter logic [7*PBS_ID_W-1:0] MODE_MAP = PBS_MAP_DEFAULT
) (
   // clock and reset
   input  wire logic                  i_ref_clk,
   input  wire logic                  i_srst,
   // mode selection
   input  wire logic                  i_format7_active,
   input  wire logic [PBS_MODE_W-1:0] i_format7_mode,
   input  wire logic                  i_is_color,
   input  wire logic [PBS_PIX_W-1:0]  i_black_level,
   // shading reference handshake
   input  wire logic                  i_shading_ref_done,
   output var  logic                  o_shading_stale,
   // sensor vertical binning factor code
   output var  logic [1:0]            o_sensor_vbin,
   // pixel streams
   input  wire pbs_pix_in_type        i_pix,
   output var  pbs_pix_out_type       o_pix
);

   // ****************************************************************
   // mode decode
   // ****************************************************************
   function automatic pbs_cfg_type decode_id(input logic [PBS_ID_W-1:0] id);
      pbs_cfg_type c;
      c.is_bin = (id < PBS_ID_SUB_BASE);
      c.h_code = id[1:0];
      c.v_code = id[3:2];
      // an all-zero binning code is plain full resolution
      if (c.is_bin && (c.h_code == 2'h0) && (c.v_code == 2'h0)) begin
         c.is_bin = 1'b0;
      end
      return c;
   endfunction : decode_id

   // sub-sampling period mask: 2 of 4 -> 3, 2 of 8 -> 7, 2 of 16 -> 15
   function automatic logic [PBS_POS_W-1:0] sub_mask(input logic [1:0] code);
      return PBS_POS_W'((5'h02 << code) - 5'h01);
   endfunction : sub_mask

   // binning group mask: 2x -> 1, 4x -> 3, 8x -> 7
   function automatic logic [PBS_POS_W-1:0] bin_mask(input logic [1:0] code);
      return PBS_POS_W'((5'h01 << code) - 5'h01);
   endfunction : bin_mask

   logic [PBS_ID_W-1:0] sel_id;
   pbs_cfg_type         cfg_sel;
   pbs_cfg_type         cfg_eff;

   always_comb begin
      sel_id = PBS_ID_FULL_RES;
      if (i_format7_active && (i_format7_mode != 3'h0)) begin
         sel_id = MODE_MAP[(32'(i_format7_mode) - 1) * PBS_ID_W +: PBS_ID_W];
      end
      // one identifier, either binning or sub-sampling
      cfg_sel = decode_id(sel_id);
      if (i_is_color && cfg_sel.is_bin) begin
         cfg_sel = PBS_CFG_NONE;
      end
   end

   // ****************************************************************
   // state
   // ****************************************************************
   pbs_cfg_type           cfg_r,   cfg_nxt;
   logic [PBS_POS_W-1:0]  x_r,     x_nxt;
   logic [PBS_POS_W-1:0]  y_r,     y_nxt;
   logic [PBS_ACC_W-1:0]  acc_r,   acc_nxt;
   logic                  stale_r, stale_nxt;
   logic [1:0]            vbin_r,  vbin_nxt;
   pbs_pix_out_type       out_r,   out_nxt;

   logic [PBS_POS_W-1:0]  x_cur;
   logic [PBS_POS_W-1:0]  y_cur;
   logic [PBS_ACC_W-1:0]  sig;
   logic [PBS_ACC_W-1:0]  acc_sum;
   logic                  line_keep;
   logic                  pix_keep;
   logic                  grp_last;

   always_comb begin
      // config only switches at frame start, never mid-frame
      cfg_eff   = i_pix.sof ? cfg_sel : cfg_r;
      x_cur     = i_pix.sof ? 4'h0 : x_r;
      y_cur     = i_pix.sof ? 4'h0 : y_r;
      cfg_nxt   = cfg_eff;
      x_nxt     = x_r;
      y_nxt     = y_r;
      acc_nxt   = acc_r;
      stale_nxt = stale_r;
      vbin_nxt  = vbin_r;
      out_nxt   = '0;

      sig = (i_pix.data > i_black_level) ?
            PBS_ACC_W'(i_pix.data - i_black_level) : '0;
      // group restarts on its first pixel
      acc_sum = (((x_cur & bin_mask(cfg_eff.h_code)) == 4'h0) ? '0 : acc_r) + sig;

      // keep first two of each period
      line_keep = 1'b1;
      pix_keep  = 1'b1;
      grp_last  = 1'b1;
      if (!cfg_eff.is_bin) begin
         if (cfg_eff.v_code != 2'h0) begin
            line_keep = ((y_cur & sub_mask(cfg_eff.v_code)) < 4'h2);
         end
         if (cfg_eff.h_code != 2'h0) begin
            pix_keep = ((x_cur & sub_mask(cfg_eff.h_code)) < 4'h2);
         end
      end else begin
         // group end or forced at end of line
         grp_last = ((x_cur & bin_mask(cfg_eff.h_code)) == bin_mask(cfg_eff.h_code))
                    || i_pix.eol;
      end

      if (i_pix.valid) begin
         // position restarts at each line boundary
         x_nxt   = i_pix.eol ? 4'h0 : x_cur + 4'h1;
         y_nxt   = i_pix.eol ? y_cur + 4'h1 : y_cur;
         acc_nxt = acc_sum;
         out_nxt.sof = i_pix.sof;
         // end of line keeps its input timing
         out_nxt.eol = i_pix.eol && line_keep;
         if (cfg_eff.is_bin) begin
            // black level restored once per sum
            out_nxt.valid = grp_last;
            out_nxt.data  = acc_sum + PBS_ACC_W'(i_black_level);
         end else begin
            out_nxt.valid = line_keep && pix_keep;
            out_nxt.data  = PBS_ACC_W'(i_pix.data);
         end
      end

      if (i_pix.valid && i_pix.sof) begin
         // vertical sums are formed in the sensor register
         vbin_nxt = cfg_eff.is_bin ? cfg_eff.v_code : 2'h0;
      end

      if (i_shading_ref_done) begin
         stale_nxt = 1'b0;
      end
      if (i_pix.valid && i_pix.sof && (cfg_sel != cfg_r)) begin
         stale_nxt = 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         cfg_r   <= PBS_CFG_NONE;
         x_r     <= '0;
         y_r     <= '0;
         acc_r   <= '0;
         stale_r <= 1'b0;
         vbin_r  <= 2'h0;
         out_r   <= '0;
      end else begin
         cfg_r   <= cfg_nxt;
         x_r     <= x_nxt;
         y_r     <= y_nxt;
         acc_r   <= acc_nxt;
         stale_r <= stale_nxt;
         vbin_r  <= vbin_nxt;
         out_r   <= out_nxt;
      end
   end

   assign o_pix           = out_r;
   assign o_sensor_vbin   = vbin_r;
   assign o_shading_stale = stale_r;

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_srst);

   sequence s_h2_pair;
      i_pix.valid && !i_pix.sof && !i_pix.eol && cfg_r.is_bin && cfg_r.h_code == 2'h1
      && x_r[0] == 1'b0 && i_pix.data >= i_black_level
      ##1 i_pix.valid && !i_pix.sof && i_pix.data >= i_black_level;
   endsequence

   property p_hbin_sum;
      s_h2_pair |=> o_pix.valid && o_pix.data == PBS_ACC_W'($past(i_pix.data, 1))
         + PBS_ACC_W'($past(i_pix.data, 2)) - PBS_ACC_W'(i_black_level);
   endproperty
   a_hbin_sum: assert property (p_hbin_sum) else $error("2x sum wrong");

   property p_hbin_hold;
      i_pix.valid && !i_pix.sof && !i_pix.eol && cfg_r.is_bin && cfg_r.h_code == 2'h3
      && x_r[2:0] != 3'h7 |=> !o_pix.valid;
   endproperty
   a_hbin_hold: assert property (p_hbin_hold) else $error("8x early output");

   property p_color_nobin;
      i_pix.valid && i_pix.sof && i_is_color |=> !cfg_r.is_bin;
   endproperty
   a_color_nobin: assert property (p_color_nobin) else $error("colour binning");

   property p_mode0_full;
      i_pix.valid && i_pix.sof && i_format7_mode == 3'h0 |=> cfg_r == PBS_CFG_NONE;
   endproperty
   a_mode0_full: assert property (p_mode0_full) else $error("mode 0 changed");

   property p_mode3_full2;
      i_pix.valid && i_pix.sof && i_format7_active && !i_is_color && i_format7_mode == 3'h3
      |=> cfg_r.is_bin && cfg_r.h_code == 2'h1 && o_sensor_vbin == 2'h1;
   endproperty
   a_mode3_full2: assert property (p_mode3_full2) else $error("mode 3 map");

   property p_vsub_drop;
      i_pix.valid && !i_pix.sof && !cfg_r.is_bin && cfg_r.v_code == 2'h1 && y_r[1] |=>
         !o_pix.valid && !o_pix.eol;
   endproperty
   a_vsub_drop: assert property (p_vsub_drop) else $error("line not dropped");

   property p_sub_raw;
      o_pix.valid && !cfg_r.is_bin |-> o_pix.data == PBS_ACC_W'($past(i_pix.data));
   endproperty
   a_sub_raw: assert property (p_sub_raw) else $error("sub-sample altered");

   property p_line_restart;
      i_pix.valid && i_pix.eol |=> x_r == 4'h0;
   endproperty
   a_line_restart: assert property (p_line_restart) else $error("no line restart");

   // a new reference pulse one cycle after the set may clear it again
   property p_stale_set;
      i_pix.valid && i_pix.sof && cfg_sel != cfg_r |=> o_shading_stale
         ##1 (o_shading_stale || $past(i_shading_ref_done));
   endproperty
   a_stale_set: assert property (p_stale_set) else $error("stale flag lost");

endmodule : pbs_binning

`default_nettype wire

// [rtl/pbs_pkg.sv]
// shared types and constants of the pixel binning / sub-sampling stage
package pbs_pkg;

   // ****************************************************************
   // widths
   // ****************************************************************
   localparam int PBS_PIX_W  = 12;
   localparam int PBS_ACC_W  = PBS_PIX_W + 3;   // eight full-scale pixels
   localparam int PBS_POS_W  = 4;               // position modulo 16
   localparam int PBS_ID_W   = 5;               // 32 mode identifiers
   localparam int PBS_MODE_W = 3;               // Format_7 mode number

   // ****************************************************************
   // mode identifiers and factory mapping of Format_7 modes 1..7
   // ****************************************************************
   localparam logic [PBS_ID_W-1:0] PBS_ID_FULL_RES = 5'h00;
   localparam logic [PBS_ID_W-1:0] PBS_ID_SUB_BASE = 5'h10;
   // mode 7 has no factory assignment and stays at full resolution
   localparam logic [7*PBS_ID_W-1:0] PBS_MAP_DEFAULT = {
      5'h00,   // mode 7
      5'h15,   // mode 6: 2 of 4 h + v sub-sampling
      5'h14,   // mode 5: 2 of 4 vertical sub-sampling
      5'h11,   // mode 4: 2 of 4 horizontal sub-sampling
      5'h05,   // mode 3: 2x full binning
      5'h04,   // mode 2: 2x vertical binning
      5'h01    // mode 1: 2x horizontal binning
   };

   // ****************************************************************
   // types
   // ****************************************************************
   // factor codes: binning 0=1x 1=2x 2=4x 3=8x; sub-sampling 0=none
   // 1=2 of 4, 2=2 of 8, 3=2 of 16
   typedef struct packed {
      logic       is_bin;
      logic [1:0] h_code;
      logic [1:0] v_code;
   } pbs_cfg_type;

   localparam pbs_cfg_type PBS_CFG_NONE = '{is_bin: 1'b0, h_code: 2'h0, v_code: 2'h0};

   typedef struct packed {
      logic                 valid;
      logic                 sof;
      logic                 eol;
      logic [PBS_PIX_W-1:0] data;
   } pbs_pix_in_type;

   typedef struct packed {
      logic                 valid;
      logic                 sof;
      logic                 eol;
      logic [PBS_ACC_W-1:0] data;
   } pbs_pix_out_type;

endpackage : pbs_pkg

// [verification/pbs_sensor_model.sv]
// sensor readout model that streams one raw frame per start request
`timescale 1ns/1ps
`default_nettype none

module pbs_sensor_model
   import pbs_pkg::*;
#(
   parameter int W = 9,
   parameter int H = 10
) (
   // clock and frame request
   input  wire logic                 i_ref_clk,
   input  wire logic                 i_start,
   input  wire logic                 i_slow,
   input  wire logic [PBS_PIX_W-1:0] i_base,
   input  wire logic [PBS_PIX_W-1:0] i_seed,
   // raw pixel stream
   output var  pbs_pix_in_type       o_pix,
   output var  logic                 o_busy
);
   int x;
   int y;

   initial begin
      o_pix  = '0;
      o_busy = 1'b0;
      forever begin
         @(posedge i_ref_clk);
         if (i_start) begin
            o_busy <= 1'b1;
            for (y = 0; y < H; y++) begin
               for (x = 0; x < W; x++) begin
                  o_pix <= '{1'b1, (x == 0 && y == 0), (x == W - 1),
                             PBS_PIX_W'(i_base + ((x * 37 + y * 11 + i_seed) & 12'h3FF))};
                  @(posedge i_ref_clk);
                  if (i_slow) begin
                     // idle bus must not look like a held pixel
                     o_pix <= '{1'b0, 1'b0, 1'b0, ~o_pix.data};
                     @(posedge i_ref_clk);
                  end
               end
            end
            o_pix  <= '{1'b0, 1'b0, 1'b0, ~o_pix.data};
            o_busy <= 1'b0;
         end
      end
   end
endmodule : pbs_sensor_model

`default_nettype wire

// [verification/tb_pbs_binning.sv]
// self-checking bench for the pixel binning / sub-sampling stage
`timescale 1ns/1ps
`default_nettype none

module tb_pbs_binning
   import pbs_pkg::*;
;
   // ****************************************************************
   // stimulus and monitor
   // ****************************************************************
   logic                  ref_clk = 1'b0;
   logic                  srst = 1'b1;
   logic                  f7_active = 1'b0;
   logic [PBS_MODE_W-1:0] f7_mode = 3'h0;
   logic                  is_color = 1'b0;
   logic [PBS_PIX_W-1:0]  black_level = 12'h000;
   logic                  ref_done = 1'b0;
   logic                  start = 1'b0;
   logic                  slow = 1'b0;
   logic [PBS_PIX_W-1:0]  seed = 12'h000;
   logic                  shading_stale;
   logic [1:0]            sensor_vbin;
   logic                  busy;
   pbs_pix_in_type        pix_in;
   pbs_pix_out_type       pix_out;
   logic [15:0]           notes[$];
   int                    n_mismatch = 0;
   int                    compares = 0;
   int                    prev_key = 0;
   int                    sof_seen = 0;
   // {format7 active, colour, mode}
   localparam logic [4:0] CASES[16] = '{5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16,
      5'h17, 5'h19, 5'h1B, 5'h1C, 5'h1D, 5'h1E, 5'h03, 5'h13, 5'h13};

   always #50 ref_clk = ~ref_clk;

   // mode 7 remapped to 8x full binning so the widest groups get exercised
   pbs_binning #(
      .MODE_MAP({5'h0F, PBS_MAP_DEFAULT[6*PBS_ID_W-1:0]})
   ) dut (.i_ref_clk(ref_clk), .i_srst(srst), .i_format7_active(f7_active),
      .i_format7_mode(f7_mode), .i_is_color(is_color), .i_black_level(black_level),
      .i_shading_ref_done(ref_done), .o_shading_stale(shading_stale),
      .o_sensor_vbin(sensor_vbin), .i_pix(pix_in), .o_pix(pix_out));

   pbs_sensor_model sensor (.i_ref_clk(ref_clk), .i_start(start), .i_slow(slow),
      .i_base(black_level), .i_seed(seed), .o_pix(pix_in), .o_busy(busy));

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic conclude();
      $display("n_mismatch %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : conclude

   always @(posedge ref_clk) begin
      if (!srst && pix_out.valid !== 1'b0)
         check("pixel", {pix_out.eol, pix_out.data}, notes.size() ? notes.pop_front() : 'x);
      if (pix_out.sof === 1'b1)
         sof_seen++;
   end

   // ****************************************************************
   // one frame: note expectations, stream it, check side outputs
   // ****************************************************************
   task automatic frame(input logic [4:0] c);
      logic bin;
      logic sub;
      logic hs;
      logic vs;
      int   g;
      int   key;
      int   acc;
      int   p;
      int   b_lv;
      int   vb;
      logic [11:0] sd;
      bin  = c[4] && !c[3] && (c[2:0] >= 3'h1 && c[2:0] <= 3'h3 || c[2:0] == 3'h7);
      sub  = c[4] && c[2:0] >= 3'h4 && c[2:0] <= 3'h6;
      key  = (bin || sub) ? int'(c[2:0]) : 0;
      g    = !bin ? 1 : (c[2:0] == 3'h7) ? 8 : (c[2:0] == 3'h2) ? 1 : 2;
      vb   = !bin ? 0 : (c[2:0] == 3'h7) ? 3 : (c[2:0] == 3'h1) ? 0 : 1;
      hs   = sub && c[2:0] != 3'h5;
      vs   = sub && c[2:0] != 3'h4;
      b_lv = $urandom_range(0, 511);
      sd   = 12'($urandom);
      @(posedge ref_clk);
      f7_active   <= c[4];
      is_color    <= c[3];
      f7_mode     <= c[2:0];
      black_level <= 12'(b_lv);
      seed        <= sd;
      slow        <= 1'($urandom_range(0, 1));
      start       <= 1'b1;
      for (int y = 0; y < 10; y++) begin
         if (vs && y % 4 >= 2)
            continue;
         acc = 0;
         for (int x = 0; x < 9; x++) begin
            p = (x * 37 + y * 11 + sd) & 12'h3FF;
            acc += p;
            if (hs ? (x % 4 < 2) : ((x + 1) % g == 0 || x == 8)) begin
               notes.push_back({1'(x == 8), 15'(hs ? p + b_lv : acc + b_lv)});
               acc = 0;
            end
         end
      end
      @(posedge ref_clk);
      start <= 1'b0;
      // busy rises on the same edge that takes start; a hang is left to the watchdog
      @(posedge ref_clk);
      while (busy !== 1'b0)
         @(posedge ref_clk);
      repeat (3) @(posedge ref_clk);
      check("sensor vbin", 16'(sensor_vbin), 16'(vb));
      check("frame starts", 16'(sof_seen), 16'h0001);
      sof_seen = 0;
      check("shading stale", 16'(shading_stale), 16'(key != prev_key));
      check("notes left", 16'(notes.size()), 16'h0000);
      prev_key = key;
      ref_done <= 1'b1;
      @(posedge ref_clk);
      ref_done <= 1'b0;
   endtask : frame

   initial begin
      void'($urandom(32'h5E1E));
      repeat (8) @(posedge ref_clk);
      check("reset outputs", 16'({pix_out.valid, sensor_vbin, shading_stale}), 16'h0000);
      srst <= 1'b0;
      foreach (CASES[i])
         frame(CASES[i]);
      conclude();
   end

   initial begin
      repeat (20000) @(posedge ref_clk);
      n_mismatch++;
      conclude();
   end
endmodule : tb_pbs_binning

`default_nettype wire
